// [host_pins_model.sv]
// Host model that drives the control and comparator pins of the switch.
`timescale 1ns/100ps
module host_pins_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire switch_fault_pkg::pins_t want_i,
  output switch_fault_pkg::pins_t pins_o
);
  logic ramped_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ramped_r <= 1'b0;
    end else if (want_i.supply_above_rise) begin
      ramped_r <= 1'b1;
    end
  end

  // Enable is held low until the first supply ramp is reported complete.
  always_comb begin
    pins_o = want_i;
    if (!ramped_r) begin
      pins_o.enable = 1'b0;
    end
  end
endmodule

// [interval_timer.sv]
// Saturating interval counter that restarts on clear and flags expiry.
`timescale 1ns/100ps
module interval_timer #(
  parameter int CW = 16,
  parameter logic [CW-1:0] LIMIT = '1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic clear_i,
  output logic done_o
);

  logic [CW-1:0] cnt_r;
  wire logic [CW-1:0] cnt_inc = cnt_r + {{(CW-1){1'b0}}, 1'b1};
  wire logic [CW-1:0] cnt_nxt =
    clear_i ? '0 : (done_o ? cnt_r : cnt_inc);

  assign done_o = cnt_r == LIMIT;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// [switch_fault_ctrl.sv]
// Fault handling control of a single-channel high-side power switch.
//
// Functional notes
// - Thermal or current protection turns switch off.
// - Either protection enters the fault state.
// - Fault state shows fault level on sense when diag_enable is high.
// - Release needs latch low, retry expired, clean.
// - Thermal fault: absolute or relative limit exceeded.
// - Absolute fault clears after hysteresis drop.
// - Relative fault clears when retry interval elapses.
// - Current limit switches channel off once the deglitch filter expires.
// - Short circuit detection passes deglitch filter.
// - Seven consecutive faults halve limit (foldback).
// - Standby restores the original limit.
// - Clean on/off cycle restores original limit.
// - Non-foldback version never halves its limit.
// - Resistor out of range selects internal limit.
// - Falling undervoltage shuts output stage down.
// - Rising undervoltage level resumes operation.
// - Latch low retries automatically; high stays off.
// - Fault state drives sense to fault level when diag_enable is high.
`timescale 1ns/100ps
module switch_fault_ctrl #(
  parameter logic [15:0] RETRY_CYCLES =
    16'(switch_fault_pkg::RETRY_CYC)
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire switch_fault_pkg::pins_t pins_i,
  output logic switch_on_o,
  output switch_fault_pkg::sense_t sense_output_o,
  output switch_fault_pkg::limit_t limit_o,
  output logic fault_state_o,
  output logic standby_o
);

  switch_fault_pkg::pins_t pin_s;
  switch_fault_pkg::state_t state_r;
  switch_fault_pkg::state_t state_nxt;
  switch_fault_pkg::sense_t sense_r;
  switch_fault_pkg::sense_t sense_nxt;
  logic [switch_fault_pkg::FAULT_CNT_W-1:0] cnt_r;
  logic [switch_fault_pkg::FAULT_CNT_W-1:0] cnt_nxt;
  logic abs_fault_r;
  logic rel_fault_r;
  logic oc_fault_r;
  logic uvlo_r;
  logic clean_r;
  logic halved_r;
  logic internal_r;
  logic switch_r;
  logic fault_r;
  logic standby_r;
  logic oc_done;
  logic retry_done;

  sync3 #(
    .W($bits(switch_fault_pkg::pins_t))
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .d_i(pins_i),
    .q_o(pin_s)
  );

  // The filter restarts whenever the current drops below the threshold.
  interval_timer #(
    .CW(switch_fault_pkg::DEGLITCH_CW),
    .LIMIT(3'(switch_fault_pkg::DEGLITCH_CYC))
  ) u_deglitch (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .clear_i(!pin_s.over_current),
    .done_o(oc_done)
  );

  wire logic in_on = state_r == switch_fault_pkg::ST_ON;
  wire logic in_off = state_r == switch_fault_pkg::ST_OFF;
  wire logic in_fault = state_r == switch_fault_pkg::ST_FAULT;
  wire logic thermal_hit = pin_s.abs_over || pin_s.rel_over;

  // A protection trip only matters while the switch conducts.
  wire logic trip = in_on && (thermal_hit || oc_done);

  interval_timer #(
    .CW(switch_fault_pkg::RETRY_CW),
    .LIMIT(RETRY_CYCLES)
  ) u_retry (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .clear_i(trip),
    .done_o(retry_done)
  );

  wire logic any_fault = abs_fault_r || rel_fault_r || oc_fault_r;
  wire logic release_ok =
    !pin_s.latch && retry_done && !any_fault;
  wire logic may_run = pin_s.enable && !uvlo_r;
  wire logic standby = in_off && !pin_s.enable && !pin_s.diag_enable;
  wire logic clean_off = in_on && !pin_s.enable && clean_r && !trip;
  wire logic restore = standby || clean_off;

  // Fault flags: a new event wins over its clear in the same cycle.
  wire logic abs_fault_nxt =
    pin_s.abs_over || (abs_fault_r && !pin_s.below_hys);
  wire logic rel_fault_nxt =
    pin_s.rel_over || (rel_fault_r && !retry_done);
  wire logic oc_fault_nxt =
    (trip && oc_done) || (oc_fault_r && pin_s.over_current);
  wire logic uvlo_nxt = pin_s.supply_below_fall ||
    (uvlo_r && !pin_s.supply_above_rise);

  wire logic enter_on = !in_on && state_nxt == switch_fault_pkg::ST_ON;
  wire logic clean_nxt =
    trip ? 1'b0 : (enter_on ? 1'b1 : (clean_off ? 1'b0 : clean_r));

  wire logic cnt_full = cnt_r == switch_fault_pkg::FAULT_CNT_MAX;
  wire logic [switch_fault_pkg::FAULT_CNT_W-1:0] cnt_inc =
    cnt_full ? cnt_r : cnt_r + switch_fault_pkg::FAULT_CNT_ONE;
  assign cnt_nxt = trip ? cnt_inc :
    (restore ? switch_fault_pkg::FAULT_CNT_RST : cnt_r);

  wire logic halved_nxt = pin_s.foldback_version &&
    cnt_nxt == switch_fault_pkg::FAULT_CNT_MAX;
  wire logic internal_nxt = !pin_s.limit_res_valid;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      switch_fault_pkg::ST_OFF: begin
        if (may_run) begin
          state_nxt = switch_fault_pkg::ST_ON;
        end
      end
      switch_fault_pkg::ST_ON: begin
        if (trip) begin
          state_nxt = switch_fault_pkg::ST_FAULT;
        end else if (!may_run) begin
          state_nxt = switch_fault_pkg::ST_OFF;
        end
      end
      switch_fault_pkg::ST_FAULT: begin
        if (release_ok && may_run) begin
          state_nxt = switch_fault_pkg::ST_ON;
        end else if (release_ok) begin
          state_nxt = switch_fault_pkg::ST_OFF;
        end
      end
      default: begin
        state_nxt = switch_fault_pkg::ST_OFF;
      end
    endcase
  end

  // Sense selection; the fault level overrides any measurement.
  always_comb begin
    sense_nxt.active = pin_s.diag_enable;
    if (!pin_s.diag_enable) begin
      sense_nxt.mode = switch_fault_pkg::SENSE_IDLE;
    end else if (in_fault) begin
      sense_nxt.mode = switch_fault_pkg::SENSE_FAULT_LEVEL;
    end else if (pin_s.sense_source_select) begin
      sense_nxt.mode = switch_fault_pkg::SENSE_TEMP;
    end else begin
      sense_nxt.mode = switch_fault_pkg::SENSE_CURRENT;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= switch_fault_pkg::ST_OFF;
      abs_fault_r <= 1'b0;
      rel_fault_r <= 1'b0;
      oc_fault_r <= 1'b0;
      uvlo_r <= switch_fault_pkg::UVLO_RST;
      clean_r <= 1'b0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      abs_fault_r <= abs_fault_nxt;
      rel_fault_r <= rel_fault_nxt;
      oc_fault_r <= oc_fault_nxt;
      uvlo_r <= uvlo_nxt;
      clean_r <= clean_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= switch_fault_pkg::FAULT_CNT_RST;
      halved_r <= 1'b0;
      internal_r <= switch_fault_pkg::LIMIT_INTERNAL_RST;
      switch_r <= 1'b0;
      fault_r <= 1'b0;
      standby_r <= 1'b0;
      sense_r <= '{mode: switch_fault_pkg::SENSE_IDLE, active: 1'b0};
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
      halved_r <= halved_nxt;
      internal_r <= internal_nxt;
      switch_r <= state_nxt == switch_fault_pkg::ST_ON;
      fault_r <= state_nxt == switch_fault_pkg::ST_FAULT;
      standby_r <= standby;
      sense_r <= sense_nxt;
    end
  end

  assign switch_on_o = switch_r;
  assign fault_state_o = fault_r;
  assign standby_o = standby_r;
  assign sense_output_o = sense_r;
  assign limit_o.use_internal = internal_r;
  assign limit_o.halved = halved_r;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i || !ce_i);

  a_trip_turns_off: assert property (
    trip |=> !switch_on_o && fault_state_o
  ) else $error("Switch still on after a protection trip.");

  a_trip_enters_fault: assert property (
    trip |=> state_r == switch_fault_pkg::ST_FAULT
  ) else $error("Trip did not enter the fault state.");

  a_fault_sense_level: assert property (
    in_fault && pin_s.diag_enable |=>
      sense_output_o.mode == switch_fault_pkg::SENSE_FAULT_LEVEL
  ) else $error("Fault state without fault level on sense.");

  a_release_held: assert property (
    in_fault && !release_ok |=> in_fault && !switch_on_o
  ) else $error("Fault released before all conditions held.");

  a_thermal_trip: assert property (
    in_on && thermal_hit |=> fault_state_o ##1 in_fault
  ) else $error("Thermal limit did not cause a fault.");

  a_abs_fault_hold: assert property (
    abs_fault_r && !pin_s.below_hys |=> abs_fault_r
  ) else $error("Absolute fault cleared before hysteresis.");

  a_rel_fault_clear: assert property (
    rel_fault_r && retry_done && !pin_s.rel_over |=> !rel_fault_r
  ) else $error("Relative fault not cleared after retry.");

  a_oc_deglitch: assert property (
    !pin_s.over_current |=> !oc_done [*3]
  ) else $error("Overcurrent passed the deglitch filter early.");

  a_foldback_count: assert property (
    halved_r |-> cnt_r == switch_fault_pkg::FAULT_CNT_MAX
  ) else $error("Limit halved before seven faults.");

  a_seventh_halves: assert property (
    trip && pin_s.foldback_version && cnt_r ==
      switch_fault_pkg::FAULT_CNT_MAX - switch_fault_pkg::FAULT_CNT_ONE |=>
      limit_o.halved
  ) else $error("Seventh fault did not halve the limit.");

  a_oc_turns_off: assert property (
    in_on && oc_done |=> !switch_on_o && in_fault
  ) else $error("Overcurrent did not switch the channel off.");

  a_count_trip: assert property (
    trip && cnt_r != switch_fault_pkg::FAULT_CNT_MAX |=>
      cnt_r == $past(cnt_r) + switch_fault_pkg::FAULT_CNT_ONE
  ) else $error("Fault counter missed a trip.");

  a_fold_version: assert property (
    !pin_s.foldback_version |=> !limit_o.halved
  ) else $error("Non-foldback version halved its limit.");

  a_restore_count: assert property (
    restore && !trip |=> cnt_r == '0 && !limit_o.halved
  ) else $error("Restore did not clear the fault count.");

  a_default_limit: assert property (
    !pin_s.limit_res_valid |=> limit_o.use_internal
  ) else $error("Out-of-range resistor kept the external limit.");

  a_uvlo_gates_out: assert property (
    uvlo_r |-> ##1 !switch_on_o
  ) else $error("Output on during undervoltage lockout.");

  a_uvlo_resume: assert property (
    in_off && pin_s.enable && !uvlo_r |=> switch_on_o
  ) else $error("Switch did not resume after undervoltage.");

  a_latch_holds: assert property (
    in_fault && pin_s.latch |=> in_fault
  ) else $error("Latched fault retried.");

  a_retry_restart: assert property (
    trip |=> !retry_done
  ) else $error("Retry timer not restarted by a trip.");

endmodule

// [switch_fault_ctrl_test.sv]
// Self-checking testbench for the switch fault protection controller.
`timescale 1ns/100ps
module switch_fault_ctrl_test;
  logic clk_i;
  logic rst_n_i;
  logic ce_i;
  switch_fault_pkg::pins_t want;
  switch_fault_pkg::pins_t pins;
  logic switch_on_o;
  switch_fault_pkg::sense_t sense_output_o;
  switch_fault_pkg::limit_t limit_o;
  logic fault_state_o;
  logic standby_o;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;

  switch_fault_ctrl #(.RETRY_CYCLES(16'h0028)) u_switch_fault_ctrl (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .pins_i(pins),
    .switch_on_o(switch_on_o),
    .sense_output_o(sense_output_o),
    .limit_o(limit_o),
    .fault_state_o(fault_state_o),
    .standby_o(standby_o)
  );

  host_pins_model u_host_pins_model (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .want_i(want),
    .pins_o(pins)
  );

  always #25 clk_i = ~clk_i;

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  // One overcurrent trip followed by automatic retry.
  task automatic trip();
    want.over_current = 1'b1;
    wait_cyc(12);
    want.over_current = 1'b0;
    wait_cyc(60);
  endtask

  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    want = '0;
    wait_cyc(16);
    rst_n_i = 1'b1;
    want.enable = 1'b1;
    wait_cyc(8);
    check(switch_on_o, 8'h00);
    check(limit_o, 8'h02);
    want.supply_above_rise = 1'b1;
    wait_cyc(8);
    check(switch_on_o, 8'h01);
    want.diag_enable = 1'b1;
    wait_cyc(8);
    check(sense_output_o, 8'h03);
    want.sense_source_select = 1'b1;
    wait_cyc(8);
    check(sense_output_o, 8'h05);
    want.sense_source_select = 1'b0;
    want.limit_res_valid = 1'b1;
    wait_cyc(8);
    check(limit_o, 8'h00);
    end_test("power_up");
    want.over_current = 1'b1;
    wait_cyc(3);
    want.over_current = 1'b0;
    wait_cyc(10);
    check(fault_state_o, 8'h00);
    want.latch = 1'b1;
    want.over_current = 1'b1;
    wait_cyc(12);
    check(switch_on_o, 8'h00);
    check(fault_state_o, 8'h01);
    check(sense_output_o, 8'h07);
    want.over_current = 1'b0;
    wait_cyc(60);
    check(fault_state_o, 8'h01);
    ce_i = 1'b0;
    want.latch = 1'b0;
    wait_cyc(8);
    check(fault_state_o, 8'h01);
    ce_i = 1'b1;
    wait_cyc(8);
    check(fault_state_o, 8'h00);
    check(switch_on_o, 8'h01);
    want.over_current = 1'b1;
    wait_cyc(12);
    want.over_current = 1'b0;
    wait_cyc(10);
    check(fault_state_o, 8'h01);
    wait_cyc(50);
    check(switch_on_o, 8'h01);
    end_test("current_limit");
    want.abs_over = 1'b1;
    wait_cyc(12);
    check(switch_on_o, 8'h00);
    want.abs_over = 1'b0;
    wait_cyc(60);
    check(fault_state_o, 8'h01);
    want.below_hys = 1'b1;
    wait_cyc(8);
    check(switch_on_o, 8'h01);
    want.below_hys = 1'b0;
    want.rel_over = 1'b1;
    wait_cyc(8);
    want.rel_over = 1'b0;
    check(fault_state_o, 8'h01);
    wait_cyc(60);
    check(switch_on_o, 8'h01);
    end_test("thermal");
    want.enable = 1'b0;
    wait_cyc(8);
    want.enable = 1'b1;
    want.foldback_version = 1'b1;
    wait_cyc(8);
    repeat (6) trip();
    check(limit_o, 8'h00);
    trip();
    check(limit_o, 8'h01);
    want.enable = 1'b0;
    want.diag_enable = 1'b0;
    wait_cyc(8);
    check(standby_o, 8'h01);
    check(sense_output_o, 8'h00);
    check(limit_o, 8'h00);
    want.foldback_version = 1'b0;
    want.enable = 1'b1;
    want.diag_enable = 1'b1;
    wait_cyc(8);
    repeat (8) trip();
    check(limit_o, 8'h00);
    end_test("foldback");
    want.supply_below_fall = 1'b1;
    want.supply_above_rise = 1'b0;
    wait_cyc(8);
    check(switch_on_o, 8'h00);
    check(fault_state_o, 8'h00);
    want.supply_below_fall = 1'b0;
    want.supply_above_rise = 1'b1;
    wait_cyc(8);
    check(switch_on_o, 8'h01);
    end_test("undervoltage");
    final_report();
  end
endmodule

// [switch_fault_pkg.sv]
// Shared constants and types for the switch fault protection controller.
package switch_fault_pkg;

  // Clock period.
  localparam int CLK_PERIOD_NS = 50;

  // Overcurrent deglitch filter, a least time, so it rounds up.
  localparam int DEGLITCH_NS = 200;
  localparam int DEGLITCH_CYC =
    (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEGLITCH_CW = 3;

  // Retry interval, a least time, so it rounds up.
  localparam int RETRY_US = 1000;
  localparam int RETRY_CYC =
    (RETRY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_CW = 16;

  // Consecutive fault shutdowns before the limit is halved.
  localparam int FAULT_CNT_W = 3;
  localparam logic [FAULT_CNT_W-1:0] FAULT_CNT_MAX = 3'h7;
  localparam logic [FAULT_CNT_W-1:0] FAULT_CNT_ONE = 3'h1;
  localparam logic [FAULT_CNT_W-1:0] FAULT_CNT_RST = 3'h0;

  // Reset values.
  localparam logic UVLO_RST = 1'b1;
  localparam logic LIMIT_INTERNAL_RST = 1'b1;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_ON,
    ST_FAULT
  } state_t;

  typedef enum logic [1:0] {
    SENSE_IDLE,
    SENSE_CURRENT,
    SENSE_TEMP,
    SENSE_FAULT_LEVEL
  } sense_mode_t;

  // Pins and comparator flags from outside the clock domain.
  typedef struct packed {
    logic enable;
    logic diag_enable;
    logic latch;
    logic sense_source_select;
    logic abs_over;
    logic below_hys;
    logic rel_over;
    logic over_current;
    logic supply_below_fall;
    logic supply_above_rise;
    logic limit_res_valid;
    logic foldback_version;
  } pins_t;

  typedef struct packed {
    sense_mode_t mode;
    logic active;
  } sense_t;

  typedef struct packed {
    logic use_internal;
    logic halved;
  } limit_t;

endpackage

// [sync3.sv]
// Three-stage input synchroniser that accepts a change once stages agree.
`timescale 1ns/100ps
module sync3 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  for (genvar b = 0; b < W; b++) begin : g_bit
    logic st1_r;
    logic st2_r;
    logic st3_r;
    logic q_r;
    wire logic agree = st2_r == st3_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        st1_r <= 1'b0;
        st2_r <= 1'b0;
        st3_r <= 1'b0;
        q_r <= 1'b0;
      end else if (ce_i) begin
        st1_r <= d_i[b];
        st2_r <= st1_r;
        st3_r <= st2_r;
        if (agree) begin
          q_r <= st3_r;
        end
      end
    end

    assign q_o[b] = q_r;
  end

endmodule
